// file: rtl/pad_pkg.sv
// package: constants and carrier structs for the parameter access and diagnosis handler
package pad_pkg;
   // ==========================================================
   // function codes and exception values
   localparam logic [7:0] FC_RD32    = 8'h64;
   localparam logic [7:0] FC_WR32    = 8'h65;
   localparam logic [7:0] FC_DIAG    = 8'h08;
   localparam logic [7:0] EXC_FLAG   = 8'h80;
   localparam logic [7:0] EXC_FUNC   = 8'h01;
   localparam logic [7:0] EXC_ADDR   = 8'h02;
   localparam logic [7:0] EXC_VALUE  = 8'h03;
   localparam logic [7:0] EXC_DEVICE = 8'h04;
   // ==========================================================
   // unit address and start address layout
   localparam logic [7:0]  UNIT_MIN   = 8'h01;
   localparam logic [7:0]  UNIT_MAX   = 8'hF7;
   localparam logic [7:0]  UNIT_BCAST = 8'h00;
   localparam logic [15:0] START_MAX  = 16'h963F;
   localparam int          PNUM_W     = 12;
   localparam int          DSET_W     = 4;
   localparam logic [11:0] PNUM_MAX   = 12'h63F;
   localparam logic [3:0]  DSET_MAX   = 4'h9;
   // ==========================================================
   // diagnosis sub-functions and required zero data word
   localparam logic [15:0] SF_CLEAR  = 16'h000A;
   localparam logic [15:0] SF_MSGS   = 16'h000B;
   localparam logic [15:0] SF_XERR   = 16'h000C;
   localparam logic [15:0] SF_EXCS   = 16'h000D;
   localparam logic [15:0] SF_SLAVE  = 16'h000E;
   localparam logic [15:0] SF_BCAST  = 16'h000F;
   localparam logic [15:0] SF_NAK    = 16'h0010;
   localparam logic [15:0] SF_BUSY   = 16'h0011;
   localparam logic [15:0] SF_CHLOSS = 16'h0012;
   localparam logic [15:0] DIAG_ZERO = 16'h0000;
   // ==========================================================
   // data field byte counts per function and counter width
   localparam logic [3:0] LEN_RD32 = 4'h2;
   localparam logic [3:0] LEN_WR32 = 4'h6;
   localparam logic [3:0] LEN_DIAG = 4'h4;
   localparam int         CNT_W    = 16;
   // ==========================================================
   // carriers
   typedef struct packed {
      logic [7:0]  unit;
      logic [7:0]  func;
      logic [15:0] word0;  // start address or sub-function
      logic [31:0] value;  // write value, or diag data in low half
      logic [3:0]  nbytes; // data field length after function code
   } pad_req_s;
   typedef struct packed {
      logic [7:0]  unit;
      logic [7:0]  func;
      logic [15:0] word0;
      logic [31:0] value;
      logic [7:0]  exc_code;
      logic        is_exc;
      logic [1:0]  kind;   // 0 read, 1 write echo, 2 diag or unknown function
   } pad_rsp_s;
   typedef struct packed {
      logic        wr;
      logic [3:0]  dset;
      logic [11:0] pnum;
      logic [31:0] wdata;
   } pad_store_req_s;
   typedef struct packed {
      logic        known;
      logic        fail;
      logic [31:0] rdata;
   } pad_store_rsp_s;
endpackage

// file: rtl/pad_diag_cnt.sv
// diagnosis counter bank: five wrapping counters with registered read data
module pad_diag_cnt #(
   parameter int W = pad_pkg::CNT_W
) (
   // clock and reset
   input  wire logic         mclk_i,
   input  wire logic         srst_i,
   // events, clear and selection
   input  wire logic [4:0]   inc_i,
   input  wire logic         clr_i,
   input  wire logic [2:0]   sel_i,
   // read data
   output logic      [W-1:0] rdata_o
);
   // elaboration check: a zero-width counter cannot count
   if (W < 1) begin : g_w_chk
      $error("counter width must be positive");
   end

   logic [W-1:0] cnt [5];

   // ==========================================================
   // counters: event beats a simultaneous clear so no event is lost
   always_ff @(posedge mclk_i) begin
      for (int i = 0; i < 5; i++) begin
         if (srst_i) begin
            cnt[i] <= '0;                                      // see RULE24
         end else if (inc_i[i]) begin
            cnt[i] <= clr_i ? W'(1) : cnt[i] + W'(1);          // see RULE24
         end else if (clr_i) begin
            cnt[i] <= '0;                                      // see RULE13
         end
      end
   end

   // ==========================================================
   // registered read port; index 5 and up read zero
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         rdata_o <= '0;
      end else if (sel_i < 3'h5) begin
         rdata_o <= cnt[sel_i];
      end else begin
         rdata_o <= '0;                                        // see RULE19
      end
   end
endmodule

// file: rtl/pad_handler.sv
// top: serves 32-bit parameter read/write and diagnosis counter requests
// Operation
// RULE1: read request: unit 1..247, 0x64, address
// RULE2: read reply: unit, function, four-byte value
// RULE3: failed access replies 0xE4 or 0xE5 plus code
// RULE4: low twelve bits give parameter, max 1599
// RULE5: top four bits give dataset, max nine
// RULE6: fractional values travel as scaled integers
// RULE7: unknown parameter gives exception code 2
// RULE8: wrong data byte count gives code 3
// RULE9: internal access failure gives code 4
// RULE10: write request: unit, 0x65, address, value
// RULE11: write reply echoes unit, function, address, value
// RULE12: function 0x08 selects counters by sub-function
// RULE13: sub-function 0x0A clears counters, echoes request
// RULE14: 0x0B counts valid messages, all addresses
// RULE15: 0x0C counts transfer error messages
// RULE16: 0x0D counts exception responses sent
// RULE17: 0x0E counts messages addressed here
// RULE18: 0x0F counts broadcast messages
// RULE19: 0x10 and 0x11 always return zero
// RULE20: 0x12 counts character data-loss messages
// RULE21: counter read needs zero data, returns count
// RULE22: exception sets function code top bit
// RULE23: unknown sub-function gives exception code 1
// RULE24: counters are 16 bits, wrap, reset clears
module pad_handler #(
   parameter logic [7:0] OWN_UNIT = 8'h01
) (
   // clock and reset
   input  wire logic                     mclk_i,
   input  wire logic                     srst_i,
   // request from transport
   input  wire logic                     req_valid_i,
   input  wire pad_pkg::pad_req_s        req_i,
   output logic                          req_ready_o,
   // frame events from transport
   input  wire logic                     ev_xfer_err_i,
   input  wire logic                     ev_char_loss_i,
   // parameter store
   output logic                          st_valid_o,
   output pad_pkg::pad_store_req_s       st_req_o,
   input  wire logic                     st_done_i,
   input  wire pad_pkg::pad_store_rsp_s  st_rsp_i,
   // response to transport
   output logic                          rsp_valid_o,
   output pad_pkg::pad_rsp_s             rsp_o
);
   // elaboration check: the own unit must be a legal individual address
   if (OWN_UNIT < pad_pkg::UNIT_MIN || OWN_UNIT > pad_pkg::UNIT_MAX) begin : g_unit_chk
      $error("own unit address out of range");
   end

   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_DEC   = 3'b001,
      S_STORE = 3'b011,
      S_DIAG  = 3'b010,
      S_RSP   = 3'b110
   } pad_state_e;

   pad_state_e          state;
   pad_pkg::pad_req_s   req;
   logic [4:0]          cnt_inc;
   logic                cnt_clr;
   logic [2:0]          cnt_sel;
   logic [15:0]         cnt_rdata;

   // ==========================================================
   // address field split
   function automatic logic addr_ok(input logic [15:0] a);
      logic [3:0]  ds;
      logic [11:0] pn;
      ds = a[15 -: pad_pkg::DSET_W];                           // see RULE5
      pn = a[pad_pkg::PNUM_W-1:0];                             // see RULE4
      return (a <= pad_pkg::START_MAX) && (ds <= pad_pkg::DSET_MAX)
             && (pn <= pad_pkg::PNUM_MAX);
   endfunction

   // diag sub-function to counter index, 7 marks unsupported
   function automatic logic [2:0] sf_index(input logic [15:0] sf);
      case (sf)
         pad_pkg::SF_MSGS:   return 3'h0;                      // see RULE14
         pad_pkg::SF_XERR:   return 3'h1;                      // see RULE15
         pad_pkg::SF_EXCS:   return 3'h2;                      // see RULE16
         pad_pkg::SF_SLAVE:  return 3'h3;                      // see RULE17
         pad_pkg::SF_BCAST:  return 3'h3 + 3'h1;               // see RULE18
         pad_pkg::SF_NAK:    return 3'h5;                      // see RULE19
         pad_pkg::SF_BUSY:   return 3'h5;                      // see RULE19
         pad_pkg::SF_CHLOSS: return 3'h6;                      // see RULE20
         default:            return 3'h7;
      endcase
   endfunction

   // the bank read register loads during decode, straight from the registered
   // sub-function, so it holds the chosen count by the diag state; selecting from
   // cnt_sel instead would hand back the previous request's counter.
   // data loss folds onto a zero slot here and is served from loss_cnt
   logic [2:0] bank_sel;
   assign bank_sel = (sf_index(req.word0) == 3'h6) ? 3'h5 : sf_index(req.word0);

   pad_diag_cnt #(.W(pad_pkg::CNT_W)) u_cnt (
      .mclk_i  (mclk_i),
      .srst_i  (srst_i),
      .inc_i   (cnt_inc),
      .clr_i   (cnt_clr),
      .sel_i   (bank_sel),
      .rdata_o (cnt_rdata)
   );

   // separate data-loss counter kept here so unused codes stay zero
   logic [15:0] loss_cnt;
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         loss_cnt <= '0;                                       // see RULE24
      end else if (ev_char_loss_i) begin
         loss_cnt <= cnt_clr ? 16'h0001 : loss_cnt + 16'h0001; // see RULE20
      end else if (cnt_clr) begin
         loss_cnt <= '0;
      end
   end

   // ==========================================================
   // counting events: messages, errors, exceptions sent, own and broadcast
   logic take;
   assign take = req_valid_i && req_ready_o;
   always_comb begin
      cnt_inc    = '0;
      cnt_inc[0] = take;                                       // see RULE14
      cnt_inc[1] = ev_xfer_err_i;                              // see RULE15
      cnt_inc[2] = (state == S_RSP) && rsp_o.is_exc;           // see RULE16
      cnt_inc[3] = take && (req_i.unit == OWN_UNIT);           // see RULE17
      cnt_inc[4] = take && (req_i.unit == pad_pkg::UNIT_BCAST); // see RULE18
   end

   // ==========================================================
   // request register and store request
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         req <= '0;
      end else if (take) begin
         req <= req_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         st_req_o <= '0;
      end else if (state == S_DEC) begin
         st_req_o.wr    <= (req.func == pad_pkg::FC_WR32);    // see RULE10
         st_req_o.dset  <= req.word0[15 -: pad_pkg::DSET_W];    // see RULE5
         st_req_o.pnum  <= req.word0[pad_pkg::PNUM_W-1:0];      // see RULE4
         st_req_o.wdata <= req.value;                          // see RULE6
      end
   end

   // ==========================================================
   // sequencer
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         state       <= S_IDLE;
         req_ready_o <= 1'b0;
         st_valid_o  <= 1'b0;
         rsp_valid_o <= 1'b0;
         rsp_o       <= '0;
         cnt_clr     <= 1'b0;
         cnt_sel     <= '0;
      end else begin
         st_valid_o  <= 1'b0;
         rsp_valid_o <= 1'b0;
         cnt_clr     <= 1'b0;
         case (state)
            S_IDLE: begin
               req_ready_o <= 1'b1;
               if (take) begin
                  req_ready_o <= 1'b0;
                  state       <= S_DEC;
               end
            end
            S_DEC: begin
               rsp_o.unit   <= req.unit;
               rsp_o.func   <= req.func;
               rsp_o.word0  <= req.word0;
               rsp_o.value  <= '0;
               rsp_o.is_exc <= 1'b0;
               rsp_o.exc_code <= '0;
               state        <= S_RSP;
               if (req.func == pad_pkg::FC_RD32 || req.func == pad_pkg::FC_WR32) begin
                  rsp_o.kind <= (req.func == pad_pkg::FC_RD32) ? 2'h0 : 2'h1;
                  if (req.nbytes != ((req.func == pad_pkg::FC_RD32) ?
                      pad_pkg::LEN_RD32 : pad_pkg::LEN_WR32)) begin
                     rsp_o.is_exc   <= 1'b1;
                     rsp_o.exc_code <= pad_pkg::EXC_VALUE;    // see RULE8
                  end else if (!addr_ok(req.word0)) begin     // see RULE1
                     rsp_o.is_exc   <= 1'b1;
                     rsp_o.exc_code <= pad_pkg::EXC_ADDR;     // see RULE7
                  end else begin
                     st_valid_o <= 1'b1;
                     state      <= S_STORE;
                  end
               end else if (req.func == pad_pkg::FC_DIAG) begin // see RULE12
                  rsp_o.kind <= 2'h2;
                  if (req.nbytes != pad_pkg::LEN_DIAG ||
                      req.value[15:0] != pad_pkg::DIAG_ZERO) begin
                     rsp_o.is_exc   <= 1'b1;
                     rsp_o.exc_code <= pad_pkg::EXC_VALUE;    // see RULE21
                  end else if (req.word0 == pad_pkg::SF_CLEAR) begin
                     cnt_clr <= 1'b1;                          // see RULE13
                  end else if (sf_index(req.word0) == 3'h7) begin
                     rsp_o.is_exc   <= 1'b1;
                     rsp_o.exc_code <= pad_pkg::EXC_FUNC;     // see RULE23
                  end else begin
                     cnt_sel <= sf_index(req.word0);
                     state   <= S_DIAG;
                  end
               end else begin
                  rsp_o.kind     <= 2'h2;
                  rsp_o.is_exc   <= 1'b1;
                  rsp_o.exc_code <= pad_pkg::EXC_FUNC;
               end
            end
            S_STORE: begin
               if (st_done_i) begin
                  state <= S_RSP;
                  if (!st_rsp_i.known) begin
                     rsp_o.is_exc   <= 1'b1;
                     rsp_o.exc_code <= pad_pkg::EXC_ADDR;     // see RULE7
                  end else if (st_rsp_i.fail) begin
                     rsp_o.is_exc   <= 1'b1;
                     rsp_o.exc_code <= pad_pkg::EXC_DEVICE;   // see RULE9
                  end else if (st_req_o.wr) begin
                     rsp_o.value <= req.value;                 // see RULE11
                  end else begin
                     rsp_o.value <= st_rsp_i.rdata;            // see RULE2
                  end
               end
            end
            S_DIAG: begin
               // bank read register was loaded at decode from the selected slot
               rsp_o.value <= {16'h0000, (cnt_sel == 3'h6) ? loss_cnt : cnt_rdata}; // see RULE21
               state       <= S_RSP;
            end
            S_RSP: begin
               rsp_valid_o <= 1'b1;
               if (rsp_o.is_exc) begin
                  rsp_o.func <= req.func | pad_pkg::EXC_FLAG;  // see RULE22 see RULE3
               end
               state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule

// file: sim/pad_handler_monitor.sv
// checker: handshake, store issue and exception timing of the request handler
module pad_handler_monitor (
   // clock and reset
   input wire logic                    mclk_i,
   input wire logic                    srst_i,
   // request and events
   input wire logic                    req_valid_i,
   input wire pad_pkg::pad_req_s       req_i,
   input wire logic                    req_ready_o,
   input wire logic                    ev_xfer_err_i,
   input wire logic                    ev_char_loss_i,
   // store and response
   input wire logic                    st_valid_o,
   input wire pad_pkg::pad_store_req_s st_req_o,
   input wire logic                    st_done_i,
   input wire pad_pkg::pad_store_rsp_s st_rsp_i,
   input wire logic                    rsp_valid_o,
   input wire pad_pkg::pad_rsp_s       rsp_o
);
   // ==========================================================
   // one clock domain, so clocking and disable are given once
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   sequence s_take;
      req_valid_i && req_ready_o;
   endsequence
   // a well formed read that must reach the store
   sequence s_rd_ok;
      s_take ##0 (req_i.func == pad_pkg::FC_RD32 && req_i.nbytes == pad_pkg::LEN_RD32
         && req_i.word0 <= pad_pkg::START_MAX && req_i.word0[11:0] <= pad_pkg::PNUM_MAX
         && req_i.word0[15:12] <= pad_pkg::DSET_MAX);
   endsequence
   sequence s_bad_func;
      s_take ##0 (req_i.func != pad_pkg::FC_RD32 && req_i.func != pad_pkg::FC_WR32
         && req_i.func != pad_pkg::FC_DIAG);
   endsequence
   // ==========================================================
   // assertions
   rsp_pulse_a: assert property (rsp_valid_o |=> !rsp_valid_o)
      else $error("response valid longer than one cycle");
   busy_hold_a: assert property (s_take |=> !req_ready_o [*2])
      else $error("ready high while a request is in work");
   store_issue_a: assert property (s_rd_ok |-> ##2 st_valid_o && !st_req_o.wr
      && st_req_o.pnum == $past(req_i.word0[11:0], 2)
      && st_req_o.dset == $past(req_i.word0[15:12], 2))
      else $error("store request missing or fields misdecoded");
   // store answer moves to the response state, which raises valid one edge later
   done_answer_a: assert property (st_done_i |-> ##2 rsp_valid_o)
      else $error("no response after store answer");
   unknown_par_a: assert property (st_done_i && !st_rsp_i.known |=>
      rsp_o.is_exc && rsp_o.exc_code == pad_pkg::EXC_ADDR)
      else $error("unknown parameter not answered with code 2");
   store_fail_a: assert property (st_done_i && st_rsp_i.known && st_rsp_i.fail |=>
      rsp_o.is_exc && rsp_o.exc_code == pad_pkg::EXC_DEVICE)
      else $error("store failure not answered with code 4");
   exc_flag_a: assert property (rsp_valid_o && rsp_o.is_exc |-> rsp_o.func[7])
      else $error("exception response without top function bit");
   bad_len_a: assert property (s_take ##0 (req_i.func == pad_pkg::FC_WR32
      && req_i.nbytes != pad_pkg::LEN_WR32) |-> ##3 rsp_valid_o && rsp_o.func == 8'hE5
      && rsp_o.exc_code == pad_pkg::EXC_VALUE)
      else $error("bad write length not refused with code 3");
   bad_func_a: assert property (s_bad_func |-> ##3 rsp_valid_o
      && rsp_o.func == ($past(req_i.func, 3) | pad_pkg::EXC_FLAG)
      && rsp_o.exc_code == pad_pkg::EXC_FUNC)
      else $error("unknown function not refused with code 1");
endmodule
bind pad_handler pad_handler_monitor i_mon (.mclk_i, .srst_i, .req_valid_i, .req_i,
   .req_ready_o, .ev_xfer_err_i, .ev_char_loss_i, .st_valid_o, .st_req_o, .st_done_i,
   .st_rsp_i, .rsp_valid_o, .rsp_o);

// file: sim/pad_store_model.sv
// parameter store model: small memory, one unknown and one failing parameter
module pad_store_model (
   // clock and reset
   input  wire logic                    mclk_i,
   input  wire logic                    srst_i,
   // request and pacing
   input  wire logic                    st_valid_i,
   input  wire pad_pkg::pad_store_req_s st_req_i,
   input  wire logic                    slow_i,
   // answer
   output logic                         st_done_o,
   output pad_pkg::pad_store_rsp_s      st_rsp_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0]             mem [16];
   logic [3:0]              cnt;
   logic                    busy;
   pad_pkg::pad_store_req_s held;
   logic [3:0]              idx;
   // dataset and parameter bits both select the slot
   assign idx = {held.dset[1:0], held.pnum[1:0]};
   // answer outside the done cycle is garbage that changes every cycle
   always_ff @(posedge mclk_i) begin
      st_done_o <= 1'b0;
      st_rsp_o  <= ~st_rsp_o;
      if (srst_i) begin
         busy     <= 1'b0;
         st_rsp_o <= '0;
         for (int i = 0; i < 16; i++) mem[i] <= 32'h0;
      end else if (st_valid_i) begin
         held <= st_req_i;
         busy <= 1'b1;
         cnt  <= slow_i ? 4'h5 : 4'h0;
      end else if (busy && cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end else if (busy) begin
         busy              <= 1'b0;
         st_done_o         <= 1'b1;
         st_rsp_o.known    <= held.pnum != 12'h123;
         st_rsp_o.fail     <= held.pnum == 12'h456;
         st_rsp_o.rdata    <= mem[idx];
         if (held.wr) mem[idx] <= held.wdata;
      end
   end
endmodule

// file: sim/tb_param_access_and_diag_handler.sv
// testbench: parameter access, error replies and diagnosis counters
module tb_param_access_and_diag_handler;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 0, srst_i = 1, req_valid_i = 0, ev_xfer_err_i = 0, ev_char_loss_i = 0;
   logic req_ready_o, st_valid_o, st_done_i, rsp_valid_o, slow = 0;
   pad_pkg::pad_req_s       req_i = '0;
   pad_pkg::pad_store_req_s st_req_o;
   pad_pkg::pad_store_rsp_s st_rsp_i;
   pad_pkg::pad_rsp_s       rsp_o, r;
   int failures = 0, cmp_count = 0;
   logic [15:0] c1;
   logic [7:0]  req_unit = 8'h01;
   always #10 mclk_i = ~mclk_i;
   pad_handler i_dut (.mclk_i, .srst_i, .req_valid_i, .req_i, .req_ready_o, .ev_xfer_err_i,
      .ev_char_loss_i, .st_valid_o, .st_req_o, .st_done_i, .st_rsp_i, .rsp_valid_o, .rsp_o);
   pad_store_model i_st (.mclk_i, .srst_i, .st_valid_i(st_valid_o), .st_req_i(st_req_o),
      .slow_i(slow), .st_done_o(st_done_i), .st_rsp_o(st_rsp_i));
   // ==========================================================
   // shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one request, held until taken, then wait for its response
   task automatic xfer(input logic [7:0] f, input logic [15:0] w, input logic [31:0] v,
      input logic [3:0] n);
      int k;
      req_i = '{unit: req_unit, func: f, word0: w, value: v, nbytes: n};
      req_valid_i = 1'b1;
      // ready is registered: seen high at a falling edge, the next rising edge takes
      for (k = 0; k < 20 && req_ready_o !== 1'b1; k++) @(negedge mclk_i);
      @(negedge mclk_i);
      req_valid_i = 1'b0;
      for (k = 0; k < 60 && rsp_valid_o !== 1'b1; k++) @(negedge mclk_i);
      if (k == 60) begin
         failures++;
         $display("MISMATCH at %0t: no response", $time);
      end
      r = rsp_o;
   endtask
   task automatic rd_cnt(input logic [15:0] sf, output logic [15:0] v);
      xfer(pad_pkg::FC_DIAG, sf, 32'h0, pad_pkg::LEN_DIAG);
      chk(r.func, pad_pkg::FC_DIAG);
      v = r.value[15:0];
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_rw();
      xfer(pad_pkg::FC_WR32, 16'h2174, 32'h2729, pad_pkg::LEN_WR32);
      chk({r.unit, r.func, r.word0}, 32'h0165_2174);
      chk(r.value, 32'h2729);
      slow = 1;
      xfer(pad_pkg::FC_WR32, 16'h963F, 32'hFFFF_FFFF, pad_pkg::LEN_WR32);
      chk(r.is_exc, 1'b0);
      xfer(pad_pkg::FC_RD32, 16'h2174, 32'h0, pad_pkg::LEN_RD32);
      chk({r.unit, r.func}, 16'h0164);
      chk(r.value, 32'h2729);
      slow = 0;
      xfer(pad_pkg::FC_RD32, 16'h963F, 32'h0, pad_pkg::LEN_RD32);
      chk(r.value, 32'hFFFF_FFFF);
      xfer(pad_pkg::FC_RD32, 16'h1174, 32'h0, pad_pkg::LEN_RD32);
      chk(r.value, 32'h0);
      $display("test rw done");
   endtask
   task automatic t_err();
      logic [15:0] a [5] = '{16'hA000, 16'h0640, 16'h9640, 16'h0123, 16'h0456};
      logic [7:0]  c [5] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h04};
      for (int i = 0; i < 5; i++) begin
         xfer(pad_pkg::FC_RD32, a[i], 32'h0, pad_pkg::LEN_RD32);
         chk({r.unit, r.func}, 16'h01E4);
         chk(r.exc_code, c[i]);
      end
      xfer(pad_pkg::FC_WR32, 16'h0456, 32'h5, pad_pkg::LEN_WR32);
      chk({r.func, r.exc_code}, 16'hE504);
      xfer(pad_pkg::FC_WR32, 16'h0001, 32'h5, 4'h5);
      chk({r.func, r.exc_code}, 16'hE503);
      xfer(pad_pkg::FC_RD32, 16'h0001, 32'h0, 4'h3);
      chk({r.func, r.exc_code}, 16'hE403);
      xfer(8'h03, 16'h0001, 32'h0, 4'h4);
      chk({r.func, r.exc_code}, 16'h8301);
      $display("test err done");
   endtask
   task automatic t_diag();
      logic [15:0] sf [5] = '{16'h000C, 16'h0012, 16'h0010, 16'h0011, 16'h000D};
      logic [15:0] ex [5] = '{16'h3, 16'h2, 16'h0, 16'h0, 16'h0};
      logic [15:0] v;
      xfer(pad_pkg::FC_DIAG, pad_pkg::SF_CLEAR, 32'h0, pad_pkg::LEN_DIAG);
      chk({r.unit, r.func, r.word0}, 32'h0108_000A);
      chk(r.value, 32'h0);
      chk(r.is_exc, 1'b0);
      // events while idle: three transfer errors, two losses
      for (int i = 0; i < 3; i++) begin
         ev_xfer_err_i = 1'b1;
         ev_char_loss_i = (i < 2);
         @(negedge mclk_i);
         ev_xfer_err_i = 1'b0;
         ev_char_loss_i = 1'b0;
         @(negedge mclk_i);
      end
      for (int i = 0; i < 5; i++) begin
         rd_cnt(sf[i], v);
         chk(v, ex[i]);
      end
      xfer(pad_pkg::FC_DIAG, 16'h0013, 32'h0, pad_pkg::LEN_DIAG);
      chk({r.func, r.exc_code}, 16'h8801);
      xfer(pad_pkg::FC_DIAG, 16'h000B, 32'h1, pad_pkg::LEN_DIAG);
      chk({r.func, r.exc_code}, 16'h8803);
      rd_cnt(pad_pkg::SF_EXCS, v);
      chk(v, 16'h2);
      // difference between two reads is the second read request itself, which the counter also counts
      rd_cnt(pad_pkg::SF_MSGS, c1);
      rd_cnt(pad_pkg::SF_MSGS, v);
      chk(v, c1 + 16'h1);
      rd_cnt(pad_pkg::SF_SLAVE, c1);
      rd_cnt(pad_pkg::SF_SLAVE, v);
      chk(v, c1 + 16'h1);
      // one broadcast message between the two reads
      rd_cnt(pad_pkg::SF_BCAST, c1);
      req_unit = pad_pkg::UNIT_BCAST;
      xfer(pad_pkg::FC_DIAG, pad_pkg::SF_MSGS, 32'h0, pad_pkg::LEN_DIAG);
      req_unit = 8'h01;
      rd_cnt(pad_pkg::SF_BCAST, v);
      chk(v, c1 + 16'h1);
      srst_i = 1'b1;
      repeat (3) @(negedge mclk_i);
      srst_i = 1'b0;
      @(negedge mclk_i);
      rd_cnt(pad_pkg::SF_XERR, v);
      chk(v, 16'h0);
      $display("test diag done");
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial begin
      repeat (3) @(negedge mclk_i);
      srst_i = 1'b0;
      @(negedge mclk_i);
      t_rw();
      t_err();
      t_diag();
      give_verdict();
   end
   // about thirty requests of at most twenty cycles each, with wide margin
   initial begin
      #100us;
      failures++;
      give_verdict();
   end
endmodule
